// ==== dwu_pkg.sv ====
// constants and types of the write-and-update command decoder
// assumes a 32-bit serial command word, eight channels
package dwu_pkg;
	localparam int DWU_WORD_BITS = 32;
	localparam int DWU_NCH = 8;
	localparam int DWU_DW = 16;
	localparam logic [5:0] DWU_LAST_BIT = 6'h1f;
	localparam logic [5:0] DWU_FULL_CNT = 6'h20;
	localparam logic [3:0] DWU_CMD_UPD_ALL = 4'h2;
	localparam logic [3:0] DWU_CMD_UPD_ONE = 4'h3;
	localparam logic [3:0] DWU_ADDR_BCAST = 4'hf;
	localparam logic [15:0] DWU_RESET_VALUE = 16'h0000;
	localparam logic [31:0] DWU_WORD_RESET = 32'h0000_0000;

	typedef struct packed {
		logic zero;
		logic [2:0] dont_care;
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [15:0] data;
		logic [3:0] feature;
	} dwu_word_t;

	typedef logic [DWU_NCH-1:0][DWU_DW-1:0] dwu_bank_t;
endpackage

// ==== dwu_decoder.sv ====
// serial write-and-update command decoder with eight input and output registers
// assumes sclk/sync_n/din from a host; sync_n is active low and frames 32 bits
//
// How it works
// - update-all group: top address bit set is invalid, except all-ones
// - update-all group: all-ones address broadcasts, loads all
// - update-one group: address 0-7 writes and updates channel
// - update-one group: top bit set is invalid, nothing updated; all-ones broadcasts, loads all
// - word: zero, don't-care, command, address, data, features
// - update-all group: write one channel, load all outputs
`timescale 1ns/1ps
`default_nettype none
module dwu_decoder (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// serial link
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din,
	// channel state
	output var dwu_pkg::dwu_bank_t input_value,
	output var dwu_pkg::dwu_bank_t dac_value,
	// event pulses
	output logic [7:0] chan_update,
	output logic load_all_outputs,
	output logic invalid_cmd
);
	import dwu_pkg::*;

	function automatic logic addr_invalid(input logic [3:0] a);
		return a[3] && (a != DWU_ADDR_BCAST);
	endfunction

	typedef enum {
		kind_none,
		kind_invalid,
		kind_bcast,
		kind_one_load_all,
		kind_one_only
	} dwu_kind_t;

	// sorts a received word into the action it asks for
	function automatic dwu_kind_t classify(input dwu_word_t cw);
		if (cw.zero || (cw.cmd != DWU_CMD_UPD_ALL && cw.cmd != DWU_CMD_UPD_ONE)) begin
			return kind_none;
		end
		if (addr_invalid(cw.addr)) begin
			return kind_invalid;
		end
		if (cw.addr == DWU_ADDR_BCAST) begin
			return kind_bcast;
		end
		if (cw.cmd == DWU_CMD_UPD_ALL) begin
			return kind_one_load_all;
		end
		return kind_one_only;
	endfunction

	// ----------------------------------------
	// link side shifter
	// ----------------------------------------
	logic link_rst;
	logic [5:0] bit_cnt;
	logic [5:0] next_bit_cnt;
	logic [31:0] shift;
	logic [31:0] next_shift;
	logic [31:0] hold;
	logic [31:0] next_hold;
	logic word_tgl;
	logic next_word_tgl;

	// frame sync high clears the bit count; sclk may stop between frames
	assign link_rst = sync_n | ~arst_n;

	always_comb begin
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_hold = hold;
		next_word_tgl = word_tgl;
		if (bit_cnt != DWU_FULL_CNT) begin
			next_bit_cnt = bit_cnt + 6'h01;
			next_shift = {shift[30:0], din};
			if (bit_cnt == DWU_LAST_BIT) begin
				next_hold = {shift[30:0], din};
				next_word_tgl = ~word_tgl;
			end
		end
	end

	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt <= 6'h00;
			shift <= DWU_WORD_RESET;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
		end
	end

	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			hold <= DWU_WORD_RESET;
			word_tgl <= 1'b0;
		end else begin
			hold <= next_hold;
			word_tgl <= next_word_tgl;
		end
	end

	// ----------------------------------------
	// crossing into clk
	// ----------------------------------------
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;
	logic word_new;
	dwu_word_t w;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			tgl_s1 <= word_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	// hold stays still for 31 sclk edges after the toggle, far beyond the sync delay
	assign word_new = tgl_s2 ^ tgl_s3;
	assign w = dwu_word_t'(hold);

	// ----------------------------------------
	// command classification
	// ----------------------------------------
	dwu_kind_t kind;
	dwu_kind_t next_kind;
	logic [2:0] chan;
	logic [2:0] next_chan;
	logic [15:0] value;
	logic [15:0] next_value;

	always_comb begin
		next_kind = kind_none;
		next_chan = chan;
		next_value = value;
		if (word_new) begin
			next_kind = classify(w);
			next_chan = w.addr[2:0];
			next_value = w.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			kind <= kind_none;
			chan <= 3'h0;
			value <= DWU_RESET_VALUE;
		end else begin
			kind <= next_kind;
			chan <= next_chan;
			value <= next_value;
		end
	end

	// ----------------------------------------
	// command execution
	// ----------------------------------------
	dwu_bank_t next_input_value;
	dwu_bank_t next_dac_value;
	logic [7:0] next_chan_update;
	logic next_load_all;
	logic next_invalid;

	always_comb begin
		next_input_value = input_value;
		next_dac_value = dac_value;
		next_chan_update = 8'h00;
		next_load_all = 1'b0;
		next_invalid = 1'b0;
		case (kind)
			kind_none: begin
			end
			kind_invalid: begin
				next_invalid = 1'b1;
			end
			kind_bcast: begin
				for (int i = 0; i < DWU_NCH; i++) begin
					next_input_value[i] = value;
					next_dac_value[i] = value;
				end
				next_chan_update = 8'hff;
				next_load_all = 1'b1;
			end
			kind_one_load_all: begin
				next_input_value[chan] = value;
				next_dac_value = next_input_value;
				next_chan_update = 8'hff;
				next_load_all = 1'b1;
			end
			kind_one_only: begin
				next_input_value[chan] = value;
				next_dac_value[chan] = value;
				next_chan_update[chan] = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			input_value <= {DWU_NCH{DWU_RESET_VALUE}};
			dac_value <= {DWU_NCH{DWU_RESET_VALUE}};
			chan_update <= 8'h00;
			load_all_outputs <= 1'b0;
			invalid_cmd <= 1'b0;
		end else begin
			input_value <= next_input_value;
			dac_value <= next_dac_value;
			chan_update <= next_chan_update;
			load_all_outputs <= next_load_all;
			invalid_cmd <= next_invalid;
		end
	end
endmodule
`default_nettype wire

// ==== dwu_host.sv ====
// serial host model
`timescale 1ns/1ps
`default_nettype none
module dwu_host (output logic sclk, output logic sync_n, output logic din);
	initial {sclk, sync_n, din} = 3'h2;
	task automatic send(logic [31:0] w, int n = 32);
		sync_n = 1'h0;
		for (int i = 31; i > 31 - n; i--) begin
			din = w[i];
			#24 sclk = 1'h1;
			#24 sclk = 1'h0;
		end
		#9 din = ~din;
		sync_n = 1'h1;
	endtask
endmodule
`default_nettype wire

// ==== dwu_decoder_chk.sv ====
// decoder checker
`timescale 1ns/1ps
`default_nettype none
module dwu_chk (
	input wire logic clk, arst_n, load_all_outputs, invalid_cmd,
	input wire logic [7:0] chan_update,
	input wire dwu_pkg::dwu_bank_t input_value, dac_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_a; load_all_outputs |-> chan_update == 8'hff && dac_value == input_value; endproperty
	a_a: assert property (p_a) else $error("a");
	property p_b; invalid_cmd |-> chan_update == 8'h00 && $stable(dac_value) && $stable(input_value); endproperty
	a_b: assert property (p_b) else $error("b");
	property p_c; chan_update != 8'h00 |=> (chan_update == 8'h00) [*8]; endproperty
	a_c: assert property (p_c) else $error("c");
	property p_one; $onehot(chan_update) |-> !load_all_outputs && !invalid_cmd; endproperty
	a_one: assert property (p_one) else $error("single update with other pulse");
	property p_quiet; chan_update == 8'h00 |-> $stable(dac_value) && $stable(input_value); endproperty
	a_quiet: assert property (p_quiet) else $error("registers moved without update");
	property p_all; chan_update == 8'hff |-> load_all_outputs && !invalid_cmd; endproperty
	a_all: assert property (p_all) else $error("all channels without load pulse");
	c_a: cover property (load_all_outputs);
	c_b: cover property (invalid_cmd);
	c_c: cover property ($onehot(chan_update));
endmodule
bind dwu_decoder dwu_chk chk (.*);
`default_nettype wire

// ==== tb_dwu_decoder.sv ====
// command decoder bench
`timescale 1ns/1ps
`default_nettype none
module tb_dwu_decoder;
	logic clk = 1'h0, arst_n = 1'h0, sclk, sync_n, din, load_all_outputs, invalid_cmd;
	logic [7:0] chan_update;
	dwu_pkg::dwu_bank_t inp = '0, dac = '0, input_value, dac_value;
	logic [521:0] q[$];
	int fail_count = 0, n_compared = 0, cyc = 0;
	always #25 clk = ~clk;
	dwu_host h (.*);
	dwu_decoder uut (.*);
	task automatic check(string s, logic [521:0] v, x);
		n_compared++;
		if (v !== x) begin
			fail_count++;
			$display("[FAIL] %s %h %h", s, x, v);
		end
	endtask
	task automatic give_verdict();
		$display("%0d %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmd(logic [3:0] c, a);
		logic [15:0] d = 16'($urandom);
		logic [7:0] cu = c[0] && !a[3] ? 8'h01 << a[2:0] : {8{!a[3] || &a}};
		if (&a) inp = {8{d}};
		else if (!a[3]) inp[a[2:0]] = d;
		if (c[0] && !a[3]) dac[a[2:0]] = d;
		else if (cu) dac = inp;
		q.push_back({cu, &cu, ~|cu, dac, inp});
		@(posedge clk) #2 h.send({1'h0, 3'($urandom), c, a, d, 4'($urandom)});
	endtask
	always @(negedge clk)
		if (++cyc > 3000) begin
			fail_count++;
			give_verdict();
		end else if (chan_update || invalid_cmd)
			check("ev", {chan_update, load_all_outputs, invalid_cmd, dac_value, input_value},
				q.size() ? q.pop_front() : 'x);
	initial begin
		void'($urandom(32'h3e63));
		repeat (5) @(posedge clk);
		#2 arst_n = 1'h1;
		for (int i = 0; i < 32; i++) cmd(4'h2 + 4'(i[4]), i[3:0]);
		@(posedge clk) #2 h.send(32'h8230_0010);
		@(posedge clk) #2 h.send(32'h0440_0010);
		@(posedge clk) #2 h.send(32'h0350_0010, 16);
		cmd(4'h3, 4'h5);
		repeat (8) @(posedge clk);
		check("q0", q.size(), 0);
		#2 arst_n = 1'h0;
		inp = '0;
		dac = '0;
		@(posedge clk) #2 check("rst", {chan_update, dac_value, input_value}, 0);
		@(posedge clk) #2 arst_n = 1'h1;
		cmd(4'h2, 4'h6);
		cmd(4'h3, 4'hc);
		cmd(4'h3, 4'h1);
		repeat (8) @(posedge clk);
		check("q", q.size(), 0);
		give_verdict();
	end
endmodule
`default_nettype wire
